// File: sof_formatter.sv
`timescale 1ns/1ps
`default_nettype none

module sof_formatter (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port from the serial control port engine
  input wire logic [14:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  // Test mode settings held elsewhere in the device
  input wire logic [3:0] test_mode_sel,
  input wire logic pattern_repeat,
  // SYSREF pin
  input wire logic sysref_pin,
  // Sample stream from the converter cores
  input wire logic smp_valid,
  input wire sof_pkg::sof_sample_s smp_in,
  // Formatted stream to the link framer
  output logic out_valid,
  output sof_pkg::sof_out_s out_word
);

  // Register storage
  logic [7:0] pat_lo_q [sof_pkg::NUM_PAT];
  logic [7:0] pat_hi_q [sof_pkg::NUM_PAT];
  logic [7:0] cbs_lo_q;
  logic [3:0] cbs_hi_q;
  logic [7:0] smp_fmt_q;
  logic [7:0] ovr_clr_q;
  logic [7:0] ovr_sts_q;
  logic [7:0] ovr_sts_d;

  // Pattern words and their read lanes
  logic [15:0] pat_word [sof_pkg::NUM_PAT];
  logic [7:0] pat_rd [sof_pkg::NUM_PAT];

  // Pattern sequencer state
  sof_pkg::sof_pat_e pat_state_q;
  sof_pkg::sof_pat_e pat_state_d;
  logic [1:0] pat_idx_q;
  logic [1:0] pat_idx_d;

  // Sample path and output stage
  logic sysref_sync;
  logic [2:0] ctrl_bits;
  logic out_valid_d;
  sof_pkg::sof_out_s out_word_d;

  // Register read path
  logic [7:0] rdata_d;

  // Write strobes for the single-byte control registers
  wire logic wr_cbs_lo = reg_wr && (reg_addr == sof_pkg::ADDR_CBS_LO);
  wire logic wr_cbs_hi = reg_wr && (reg_addr == sof_pkg::ADDR_CBS_HI);
  wire logic wr_smp_fmt = reg_wr && (reg_addr == sof_pkg::ADDR_SMP_FMT);
  wire logic wr_ovr_clr = reg_wr && (reg_addr == sof_pkg::ADDR_OVR_CLR);

  // Read address hits; the status register has no write strobe, so writes to it are dropped
  wire logic rd_cbs_lo = (reg_addr == sof_pkg::ADDR_CBS_LO);
  wire logic rd_cbs_hi = (reg_addr == sof_pkg::ADDR_CBS_HI);
  wire logic rd_smp_fmt = (reg_addr == sof_pkg::ADDR_SMP_FMT);
  wire logic rd_ovr_clr = (reg_addr == sof_pkg::ADDR_OVR_CLR);
  wire logic rd_ovr_sts = (reg_addr == sof_pkg::ADDR_OVR_STS);

  // User pattern bytes: the two bytes of each pattern sit at consecutive offsets
  for (genvar g = 0; g < sof_pkg::NUM_PAT; g++) begin : gen_pat
    localparam logic [14:0] LO_ADDR = 15'(sof_pkg::ADDR_UP1_LO + 15'(2 * g));
    localparam logic [14:0] HI_ADDR = 15'(sof_pkg::ADDR_UP1_HI + 15'(2 * g));
    wire logic wr_lo = reg_wr && (reg_addr == LO_ADDR);
    wire logic wr_hi = reg_wr && (reg_addr == HI_ADDR);

    // Both bytes reset to zero
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        pat_lo_q[g] <= sof_pkg::RST_UP;
        pat_hi_q[g] <= sof_pkg::RST_UP;
      end else begin
        if (wr_lo) begin
          pat_lo_q[g] <= reg_wdata;
        end
        if (wr_hi) begin
          pat_hi_q[g] <= reg_wdata;
        end
      end
    end

    // Whole word for the sequencer and byte lanes for the read mux
    assign pat_word[g] = {pat_hi_q[g], pat_lo_q[g]};
    assign pat_rd[g] = ({8{reg_addr == LO_ADDR}} & pat_lo_q[g]) | ({8{reg_addr == HI_ADDR}} & pat_hi_q[g]);
  end

  // Control registers; the upper nibble of the second select register is not stored
  // because it is reserved and must always read back as zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cbs_lo_q <= sof_pkg::RST_CBS_LO;
      cbs_hi_q <= sof_pkg::RST_CBS_HI;
      smp_fmt_q <= sof_pkg::RST_SMP_FMT;
      ovr_clr_q <= sof_pkg::RST_OVR_CLR;
    end else begin
      if (wr_cbs_lo) begin
        cbs_lo_q <= reg_wdata;
      end
      if (wr_cbs_hi) begin
        cbs_hi_q <= reg_wdata[3:0];
      end
      if (wr_smp_fmt) begin
        smp_fmt_q <= reg_wdata;
      end
      if (wr_ovr_clr) begin
        ovr_clr_q <= reg_wdata;
      end
    end
  end

  // Field views of the control registers
  wire logic [3:0] sel_cb0 = cbs_lo_q[sof_pkg::CB0_LSB +: sof_pkg::SEL_W];
  wire logic [3:0] sel_cb1 = cbs_lo_q[sof_pkg::CB1_LSB +: sof_pkg::SEL_W];
  wire logic [3:0] sel_cb2 = cbs_hi_q[sof_pkg::CB2_LSB +: sof_pkg::SEL_W];
  wire logic invert_en = smp_fmt_q[sof_pkg::INV_BIT];
  wire logic [1:0] fmt_sel = smp_fmt_q[sof_pkg::FMT_LSB +: sof_pkg::FMT_W];

  // One-hot of the virtual converter whose sample came in overranged
  wire logic [7:0] ovr_hit = (smp_valid && smp_in.overrange) ? (8'h01 << smp_in.conv_idx) : 8'h00;

  // Clear is a level, so a held clear bit keeps the flag low;
  // a new overrange still wins over the clear so no event is ever lost
  assign ovr_sts_d = (ovr_sts_q & ~ovr_clr_q) | ovr_hit;

  // Sticky status, read only from the bus side
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ovr_sts_q <= sof_pkg::RST_OVR_STS;
    end else begin
      ovr_sts_q <= ovr_sts_d;
    end
  end

  // SYSREF arrives from a pin, so it is filtered before it can steer a control bit
  sof_pin_sync u_sysref_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(sysref_pin),
    .level_out(sysref_sync)
  );

  // Control bit 0 source
  sof_ctrl_sel u_cb0 (
    .sel(sel_cb0),
    .overrange(smp_in.overrange),
    .sig_mon(smp_in.sig_mon),
    .fast_detect_flag(smp_in.fast_detect_flag),
    .sysref(sysref_sync),
    .bit_out(ctrl_bits[0])
  );

  // Control bit 1 source
  sof_ctrl_sel u_cb1 (
    .sel(sel_cb1),
    .overrange(smp_in.overrange),
    .sig_mon(smp_in.sig_mon),
    .fast_detect_flag(smp_in.fast_detect_flag),
    .sysref(sysref_sync),
    .bit_out(ctrl_bits[1])
  );

  // Control bit 2 source
  sof_ctrl_sel u_cb2 (
    .sel(sel_cb2),
    .overrange(smp_in.overrange),
    .sig_mon(smp_in.sig_mon),
    .fast_detect_flag(smp_in.fast_detect_flag),
    .sysref(sysref_sync),
    .bit_out(ctrl_bits[2])
  );

  // Inversion comes first, then coding; offset binary is the sign bit flipped
  wire logic [15:0] inv_data = invert_en ? ~smp_in.data : smp_in.data;
  // Unlisted format codes are left as twos complement, the safe default
  wire logic [15:0] coded_data = (fmt_sel == sof_pkg::FMT_OFFSET_BIN) ? {~inv_data[15], inv_data[14:0]} : inv_data;

  // User pattern mode decode and sequencer views
  wire logic pat_mode = (test_mode_sel == sof_pkg::TEST_USER_PAT);
  wire logic in_play = (pat_state_q == sof_pkg::PS_PLAY);
  wire logic in_zero = (pat_state_q == sof_pkg::PS_ZERO);
  wire logic at_last = (pat_idx_q == sof_pkg::PAT_LAST);
  wire logic single_run = (pattern_repeat == sof_pkg::REPEAT_SINGLE);

  // Sequencer next state; leaving the test mode returns at once to sample traffic
  always_comb begin
    pat_state_d = pat_state_q;
    pat_idx_d = pat_idx_q;
    case (pat_state_q)
      sof_pkg::PS_NORMAL: begin
        if (pat_mode) begin
          pat_state_d = sof_pkg::PS_PLAY;
          pat_idx_d = 2'h0;
        end
      end
      sof_pkg::PS_PLAY: begin
        if (!pat_mode) begin
          pat_state_d = sof_pkg::PS_NORMAL;
          pat_idx_d = 2'h0;
        end else if (at_last) begin
          pat_idx_d = 2'h0;
          if (single_run) begin
            pat_state_d = sof_pkg::PS_ZERO;
          end
        end else begin
          pat_idx_d = pat_idx_q + 2'h1;
        end
      end
      sof_pkg::PS_ZERO: begin
        if (!pat_mode) begin
          pat_state_d = sof_pkg::PS_NORMAL;
        end
      end
      default: begin
        pat_state_d = sof_pkg::PS_NORMAL;
        pat_idx_d = 2'h0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pat_state_q <= sof_pkg::PS_NORMAL;
      pat_idx_q <= 2'h0;
    end else begin
      pat_state_q <= pat_state_d;
      pat_idx_q <= pat_idx_d;
    end
  end

  // Pattern data: each pattern for one clock, then zeros once a single run is done
  wire logic [15:0] pat_data = in_play ? pat_word[pat_idx_q] : 16'h0000;
  wire logic pat_active = pat_mode && (in_play || in_zero);

  // In the test mode converter samples are dropped; the control bits read zero there
  assign out_valid_d = pat_mode ? pat_active : smp_valid;
  assign out_word_d = pat_mode ? sof_pkg::sof_out_s'{data: pat_data, ctrl: 3'h0}
                               : sof_pkg::sof_out_s'{data: coded_data, ctrl: ctrl_bits};

  // Output stage; the word holds between samples to keep the link lanes quiet
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_valid <= 1'h0;
      out_word <= '0;
    end else begin
      out_valid <= out_valid_d;
      if (out_valid_d) begin
        out_word <= out_word_d;
      end
    end
  end

  // Read data mux: address hits are one-hot, so the lanes can simply be ORed
  assign rdata_d = pat_rd[0] | pat_rd[1] | pat_rd[2] | pat_rd[3]
                 | ({8{rd_cbs_lo}} & cbs_lo_q)
                 | ({8{rd_cbs_hi}} & {4'h0, cbs_hi_q})
                 | ({8{rd_smp_fmt}} & smp_fmt_q)
                 | ({8{rd_ovr_clr}} & ovr_clr_q)
                 | ({8{rd_ovr_sts}} & ovr_sts_q);

  // Read answer comes one clock after the strobe is sampled;
  // the data holds until the next read so a slow master can still take it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rd_valid <= 1'h0;
      reg_rdata <= 8'h00;
    end else begin
      reg_rd_valid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
    end
  end

endmodule

`default_nettype wire

// File: sof_pkg.sv
package sof_pkg;

  // Register offsets on the serial control port (15-bit address space)
  localparam logic [14:0] ADDR_UP1_LO = 15'h0551;
  localparam logic [14:0] ADDR_UP1_HI = 15'h0552;
  localparam logic [14:0] ADDR_UP2_LO = 15'h0553;
  localparam logic [14:0] ADDR_UP2_HI = 15'h0554;
  localparam logic [14:0] ADDR_UP3_LO = 15'h0555;
  localparam logic [14:0] ADDR_UP3_HI = 15'h0556;
  localparam logic [14:0] ADDR_UP4_LO = 15'h0557;
  localparam logic [14:0] ADDR_UP4_HI = 15'h0558;
  localparam logic [14:0] ADDR_CBS_LO = 15'h0559;
  localparam logic [14:0] ADDR_CBS_HI = 15'h055A;
  localparam logic [14:0] ADDR_SMP_FMT = 15'h0561;
  localparam logic [14:0] ADDR_OVR_CLR = 15'h0562;
  localparam logic [14:0] ADDR_OVR_STS = 15'h0563;

  // Reset values
  localparam logic [7:0] RST_UP = 8'h00;
  localparam logic [7:0] RST_CBS_LO = 8'h00;
  localparam logic [3:0] RST_CBS_HI = 4'h1;
  localparam logic [7:0] RST_SMP_FMT = 8'h01;
  localparam logic [7:0] RST_OVR_CLR = 8'h00;
  localparam logic [7:0] RST_OVR_STS = 8'h00;

  // Field positions
  localparam int CB0_LSB = 0;
  localparam int CB1_LSB = 4;
  localparam int CB2_LSB = 0;
  localparam int SEL_W = 4;
  localparam int INV_BIT = 2;
  localparam int FMT_LSB = 0;
  localparam int FMT_W = 2;

  // Control bit source codes
  localparam logic [3:0] SEL_TIE_LOW = 4'h0;
  localparam logic [3:0] SEL_OVERRANGE = 4'h1;
  localparam logic [3:0] SEL_SIG_MON = 4'h2;
  localparam logic [3:0] SEL_FAST_DET = 4'h3;
  localparam logic [3:0] SEL_SYSREF = 4'h5;

  // Output coding codes
  localparam logic [1:0] FMT_OFFSET_BIN = 2'h0;
  localparam logic [1:0] FMT_TWOS_COMP = 2'h1;

  // Test mode code for user patterns and repeat control values
  localparam logic [3:0] TEST_USER_PAT = 4'h8;
  localparam logic REPEAT_CONT = 1'h0;
  localparam logic REPEAT_SINGLE = 1'h1;

  localparam int NUM_PAT = 4;
  localparam int NUM_VCONV = 8;
  localparam logic [1:0] PAT_LAST = 2'h3;

  // One converter sample with its flags, as delivered by the cores
  typedef struct packed {
    logic [2:0] conv_idx;
    logic [15:0] data;
    logic overrange;
    logic sig_mon;
    logic fast_detect_flag;
  } sof_sample_s;

  // Formatted output word to the link framer
  typedef struct packed {
    logic [15:0] data;
    logic [2:0] ctrl;
  } sof_out_s;

  // Pattern sequencer states
  typedef enum logic [2:0] {
    PS_NORMAL = 3'b001,
    PS_PLAY = 3'b010,
    PS_ZERO = 3'b100
  } sof_pat_e;

endpackage

// File: sof_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sof_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Asynchronous pin and its filtered level
  input wire logic pin_in,
  output logic level_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Three stages; first stage only feeds the second to keep metastability contained
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= 1'h0;
      s2_q <= 1'h0;
      s3_q <= 1'h0;
      level_out <= 1'h0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_out <= s3_q; // Change accepted once two stages agree
      end
    end
  end

endmodule

`default_nettype wire

// File: sof_ctrl_sel.sv
`timescale 1ns/1ps
`default_nettype none

module sof_ctrl_sel (
  // Source select code
  input wire logic [3:0] sel,
  // Candidate sources
  input wire logic overrange,
  input wire logic sig_mon,
  input wire logic fast_detect_flag,
  input wire logic sysref,
  // Chosen control bit
  output logic bit_out
);

  wire logic is_ovr = (sel == sof_pkg::SEL_OVERRANGE);
  wire logic is_mon = (sel == sof_pkg::SEL_SIG_MON);
  wire logic is_fd = (sel == sof_pkg::SEL_FAST_DET);
  wire logic is_sr = (sel == sof_pkg::SEL_SYSREF);

  // Tie-low and every unlisted code fall through to zero
  assign bit_out = (is_ovr & overrange) | (is_mon & sig_mon) | (is_fd & fast_detect_flag) | (is_sr & sysref);

endmodule

`default_nettype wire

// File: sof_formatter_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sof_chk (
  // Watched ports
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [14:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  input wire logic [3:0] test_mode_sel,
  input wire logic pattern_repeat,
  input wire logic smp_valid,
  input wire logic out_valid,
  input wire sof_pkg::sof_out_s out_word
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // User pattern mode decode
  wire pm = test_mode_sel == sof_pkg::TEST_USER_PAT;
  property p_ans; reg_rd |-> ##[0:4] reg_rd_valid; endproperty
  a_ans: assert property (p_ans) else $error("read not answered");
  property p_rsv; reg_rd_valid && reg_addr == sof_pkg::ADDR_CBS_HI |-> reg_rdata[7:4] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved nibble set");
  property p_vld; smp_valid && !pm |-> ##[0:4] out_valid; endproperty
  a_vld: assert property (p_vld) else $error("sample lost");
  property p_idle; (!smp_valid && !pm)[*6] |=> !out_valid; endproperty
  a_idle: assert property (p_idle) else $error("word without sample");
  property p_pat; $rose(pm) |-> ##[0:6] out_valid; endproperty
  a_pat: assert property (p_pat) else $error("no pattern output");
  property p_zero; (pm && pattern_repeat)[*8] |=> out_word.data == 16'h0000; endproperty
  a_zero: assert property (p_zero) else $error("single run not zero");
  property p_cont; (pm && !pattern_repeat)[*8] |-> out_valid; endproperty
  a_cont: assert property (p_cont) else $error("pattern gap");
  property p_cyc; (pm && !pattern_repeat)[*8] |-> out_word.data == $past(out_word.data, 4); endproperty
  a_cyc: assert property (p_cyc) else $error("period not four");
  // Main scenarios reached
  c_rd: cover property (reg_rd_valid);
  c_smp: cover property (smp_valid && !pm);
  c_pat: cover property (pm && out_valid);
endmodule
bind sof_formatter sof_chk u_chk (.*);
`default_nettype wire

// File: sof_sink.sv
`timescale 1ns/1ps
`default_nettype none
module sof_sink (
  // Stream from the formatter
  input wire logic clk,
  input wire logic out_valid,
  input wire sof_pkg::sof_out_s out_word,
  // Last word and count
  output sof_pkg::sof_out_s last_q,
  output logic [7:0] cnt_q
);
  // Count starts from zero; the framer model has no reset of its own
  initial cnt_q = 8'h00;
  // Framer never stalls, so every valid word is taken
  always @(posedge clk) if (out_valid) {last_q, cnt_q} <= {out_word, cnt_q + 8'h01};
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, smp_valid = 0, pattern_repeat = 0, sysref_pin = 0;
  logic [14:0] reg_addr = 15'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, cnt;
  logic [3:0] test_mode_sel = 4'h0;
  logic reg_rd_valid, out_valid;
  sof_pkg::sof_sample_s smp_in = '0;
  sof_pkg::sof_out_s out_word, last;
  int fails = 0, tests_run = 0, n;
  always #10 clk = ~clk;
  sof_formatter DUT (.*);
  sof_sink SNK (.clk(clk), .out_valid(out_valid), .out_word(out_word), .last_q(last), .cnt_q(cnt));
  task automatic ck(input logic [18:0] g, e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t %h %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(negedge clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge clk) reg_wr = 1'b0;
  endtask
  // Request held until the answer is seen
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    @(negedge clk) {reg_addr, reg_rd} = {a, 1'b1};
    for (n = 0; n < 9 && reg_rd_valid !== 1'b1; n++) @(posedge clk) #1;
    if (n == 9) begin fails++; close_out; end
    ck(reg_rdata, e);
    @(negedge clk) reg_rd = 1'b0;
  endtask
  task automatic snd(input logic [15:0] d, input logic [2:0] f, input logic [18:0] e);
    @(negedge clk) {smp_valid, smp_in} = {1'b1, 3'h3, d, f};
    @(negedge clk) smp_valid = 1'b0;
    repeat (6) @(negedge clk);
    ck(last, e);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    rd(15'h0552, 8'h00);
    rd(15'h0559, 8'h00);
    rd(15'h055A, 8'h01);
    rd(15'h0561, 8'h01);
    rd(15'h0562, 8'h00);
    wr(15'h055A, 8'hF3);
    rd(15'h055A, 8'h03);
    wr(15'h0559, 8'h21);
    snd(16'h1234, 3'b101, {16'h1234, 3'b101});
    rd(15'h0563, 8'h08);
    wr(15'h0562, 8'h08);
    wr(15'h0562, 8'h00);
    rd(15'h0563, 8'h00);
    // Unlisted code on bit 0, synchronised SYSREF on bit 1
    sysref_pin = 1'b1;
    wr(15'h0559, 8'h54);
    wr(15'h055A, 8'h00);
    snd(16'h8001, 3'b111, {16'h8001, 3'b010});
    wr(15'h0561, 8'h00);
    snd(16'h1234, 3'b000, {16'h9234, 3'b010});
    wr(15'h0561, 8'h05);
    snd(16'h1234, 3'b000, {16'hEDCB, 3'b010});
    ck(19'(cnt), 19'h00004);
    for (int i = 0; i < 8; i++) wr(15'h0551 + 15'(i), 8'(8'h11 * (i / 2 + 1)));
    rd(15'h0558, 8'h44);
    @(negedge clk) {test_mode_sel, pattern_repeat} = {4'h8, 1'b1};
    for (n = 0; n < 9 && out_word.data !== 16'h1111; n++) @(posedge clk) #1;
    if (n == 9) begin fails++; close_out; end
    for (int k = 2; k < 6; k++) begin
      @(posedge clk) #1;
      ck(out_word.data, k < 5 ? 16'h1111 * k : 16'h0000);
    end
    close_out;
  end
endmodule
`default_nettype wire
